//--- rtl/csse_map.svh
/*
 constants for the shift, jump, store, subtract, trap and xor slice.
 assumes inclusion by csse_exec.sv and the bench only; csse_pkg.sv does not include it.
*/
`ifndef CSSE_MAP_SVH
`define CSSE_MAP_SVH
// ==========================================
// opcodes
`define CSSE_OP_SHIFT_RIGHT_LOGICAL_DWORD      8'h0c
`define CSSE_OP_SKIP      8'h00
`define CSSE_OP_TRAP      8'hf7
`define CSSE_PFX_SHORT_RELATIVE_JUMP     5'h04
`define CSSE_PFX_STW      6'h30
`define CSSE_PFX_STB      6'h31
`define CSSE_PFX_SUB2W    6'h1a
`define CSSE_PFX_SUB3W    6'h12
`define CSSE_PFX_SUB3B    6'h16
`define CSSE_PFX_SUB2B    6'h1e
`define CSSE_PFX_SUBCW    6'h2a
`define CSSE_PFX_SUBTRACT_BYTE_BORROW_OP    6'h2e
`define CSSE_PFX_XORW     6'h21
`define CSSE_PFX_EXCLUSIVE_OR_BYTE_OP     6'h25
// ==========================================
// operand limits, trap vector and stack step
`define CSSE_IMM_CNT_MAX  8'h0f
`define CSSE_TRAP_VECTOR  16'h2010
`define CSSE_SP_STEP      16'h0002
// ==========================================
// state counts
`define CSSE_ST_SHIFT     6'h07
`define CSSE_ST_SHIFT0    6'h08
`define CSSE_ST_SHORT_RELATIVE_JUMP      6'h08
`define CSSE_ST_SKIP      6'h04
`define CSSE_ST_TWO_OP    6'h04
`define CSSE_ST_THREE_OP  6'h05
`define CSSE_ST_TRAP_ON   6'h15
`define CSSE_ST_TRAP_OFF  6'h18
// ==========================================
// instruction bytes
`define CSSE_LEN_SHIFT    16'h0003
`define CSSE_LEN_TWO      16'h0002
`define CSSE_LEN_THREE    16'h0003
`define CSSE_LEN_TRAP     16'h0001
// ==========================================
// addressing extras by mode (aa = 0..3)
`define CSSE_BEA_M0       16'h0000
`define CSSE_BEA_M1       16'h0001
`define CSSE_BEA_M2       16'h0000
`define CSSE_BEA_M3       16'h0001
`define CSSE_CEA_M0       6'h00
`define CSSE_CEA_M1       6'h01
`define CSSE_CEA_M2       6'h03
`define CSSE_CEA_M3       6'h04
// ==========================================
// flag positions and reset
`define CSSE_FL_ZERO      0
`define CSSE_FL_NEG       1
`define CSSE_FL_CARRY     2
`define CSSE_FL_OVF       3
`define CSSE_FL_VT        4
`define CSSE_FL_STICKY    5
`define CSSE_FLAGS_RST    6'h00
`endif

//--- rtl/csse_pkg.sv
/*
 types for the execute slice.
 assumes csse_map.svh alongside.
*/
package csse_pkg;
	typedef enum logic [1:0] {
		CSSE_IDLE = 2'b01,
		CSSE_RUN  = 2'b10
	} csse_state_e;
endpackage : csse_pkg

//--- rtl/csse_exec.sv
/*
 decode and execute for one instruction slice of a 16-bit cpu.
 assumes operands fetched by the caller and held while busy; same clock.
*/
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "csse_map.svh"

module csse_exec (
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic        start,
	input  wire logic [7:0]  opcode,
	input  wire logic [7:0]  second_byte,
	input  wire logic [7:0]  count_reg_val,
	input  wire logic [31:0] opnd_a,
	input  wire logic [15:0] opnd_b,
	input  wire logic [15:0] pc_in,
	input  wire logic [15:0] sp_in,
	input  wire logic        stack_onchip,
	input  wire logic [15:0] vector_data,
	output logic             busy,
	output logic             done,
	output logic             wr_en,
	output logic [1:0]       wr_size,
	output logic [31:0]      result,
	output logic [15:0]      pc_out,
	output logic             sp_wr,
	output logic [15:0]      sp_out,
	output logic             push_en,
	output logic [15:0]      push_data,
	output logic [15:0]      vector_addr,
	output logic [5:0]       flags,
	output logic             int_block
);
	// ==========================================
	// reset release
	logic rst_meta_r;
	logic rst_sync_r;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end
	wire rst_n_int = rst_sync_r;

	// ==========================================
	// decode
	logic [1:0]  state_r;
	logic        run_trap_r;
	logic [5:0]  flag_r;
	wire         idle     = (state_r == csse_pkg::CSSE_IDLE);
	wire         start_ok = start && idle;
	wire  [1:0]  aa       = opcode[1:0];
	wire  [5:0]  pfx      = opcode[7:2];
	wire is_shift_right_logical_dword  = (opcode == `CSSE_OP_SHIFT_RIGHT_LOGICAL_DWORD);
	wire is_skip  = (opcode == `CSSE_OP_SKIP);
	wire is_trap  = (opcode == `CSSE_OP_TRAP);
	wire is_short_relative_jump  = (opcode[7:3] == `CSSE_PFX_SHORT_RELATIVE_JUMP);
	wire is_stw   = (pfx == `CSSE_PFX_STW);
	wire is_stb   = (pfx == `CSSE_PFX_STB);
	wire is_sub2w = (pfx == `CSSE_PFX_SUB2W);
	wire is_sub3w = (pfx == `CSSE_PFX_SUB3W);
	wire is_sub3b = (pfx == `CSSE_PFX_SUB3B);
	wire is_sub2b = (pfx == `CSSE_PFX_SUB2B);
	wire is_subcw = (pfx == `CSSE_PFX_SUBCW);
	wire is_subtract_byte_borrow_op = (pfx == `CSSE_PFX_SUBTRACT_BYTE_BORROW_OP);
	wire is_xorw  = (pfx == `CSSE_PFX_XORW);
	wire is_exclusive_or_byte_op  = (pfx == `CSSE_PFX_EXCLUSIVE_OR_BYTE_OP);
	wire is_subtract_word_borrow_op  = is_subcw || is_subtract_byte_borrow_op;
	wire is_sub   = is_sub2w || is_sub3w || is_sub3b || is_sub2b || is_subtract_word_borrow_op;
	wire is_xor   = is_xorw || is_exclusive_or_byte_op;
	wire is_store = is_stw || is_stb;
	wire is_byte  = is_stb || is_sub3b || is_sub2b || is_subtract_byte_borrow_op || is_exclusive_or_byte_op;
	wire is_three = is_sub3w || is_sub3b;
	wire is_two   = is_store || is_sub2w || is_sub2b || is_subtract_word_borrow_op || is_xor;
	wire known    = is_shift_right_logical_dword || is_skip || is_trap || is_short_relative_jump || is_two || is_three;

	// ==========================================
	// addressing extras
	wire [15:0] bea = (aa == 2'd0) ? `CSSE_BEA_M0 : (aa == 2'd1) ? `CSSE_BEA_M1 :
	                  (aa == 2'd2) ? `CSSE_BEA_M2 : `CSSE_BEA_M3;
	wire [5:0]  cea = (aa == 2'd0) ? `CSSE_CEA_M0 : (aa == 2'd1) ? `CSSE_CEA_M1 :
	                  (aa == 2'd2) ? `CSSE_CEA_M2 : `CSSE_CEA_M3;

	// ==========================================
	// shift count
	wire [7:0] cnt_src = (second_byte <= `CSSE_IMM_CNT_MAX) ? second_byte : count_reg_val;
	wire [5:0] shift_n = {1'b0, cnt_src[4:0]};

	// ==========================================
	// length and state count
	wire [15:0] ins_len = is_shift_right_logical_dword ? `CSSE_LEN_SHIFT :
	                      is_trap ? `CSSE_LEN_TRAP :
	                      is_three ? (`CSSE_LEN_THREE + bea) :
	                      is_two ? (`CSSE_LEN_TWO + bea) : `CSSE_LEN_TWO;
	wire [5:0] n_states = is_shift_right_logical_dword ? ((shift_n == 6'h00) ? `CSSE_ST_SHIFT0 : (`CSSE_ST_SHIFT + shift_n)) :
	                      is_short_relative_jump ? `CSSE_ST_SHORT_RELATIVE_JUMP :
	                      is_skip ? `CSSE_ST_SKIP :
	                      is_trap ? (stack_onchip ? `CSSE_ST_TRAP_ON : `CSSE_ST_TRAP_OFF) :
	                      is_three ? (`CSSE_ST_THREE_OP + cea) :
	                      (`CSSE_ST_TWO_OP + cea);
	wire [15:0] seq_pc  = pc_in + ins_len;
	wire [15:0] disp    = {{5{opcode[2]}}, opcode[2:0], second_byte};
	wire [15:0] jmp_pc  = seq_pc + disp;

	// ==========================================
	// subtract, xor and store values
	wire        c_in    = flag_r[`CSSE_FL_CARRY];
	wire [16:0] bin     = {16'h0000, is_subtract_word_borrow_op && !c_in};
	wire [15:0] sa      = is_byte ? {8'h00, opnd_a[7:0]} : opnd_a[15:0];
	wire [15:0] sb      = is_byte ? {8'h00, opnd_b[7:0]} : opnd_b;
	wire [16:0] diff    = {1'b0, sa} - {1'b0, sb} - bin;
	wire        borrow  = is_byte ? diff[8] : diff[16];
	wire [15:0] dres    = is_byte ? {8'h00, diff[7:0]} : diff[15:0];
	wire        msb_a   = is_byte ? sa[7] : sa[15];
	wire        msb_b   = is_byte ? sb[7] : sb[15];
	wire        msb_r   = is_byte ? dres[7] : dres[15];
	wire        sub_ovf = (msb_a ^ msb_b) && (msb_a ^ msb_r);
	wire [15:0] xres    = sa ^ sb;
	wire        xmsb    = is_byte ? xres[7] : xres[15];
	wire [15:0] store_v = is_byte ? {8'h00, opnd_a[7:0]} : opnd_a[15:0];

	// ==========================================
	// flag update at start
	logic [5:0] flag_start;
	always_comb begin
		flag_start = flag_r;
		if (is_sub) begin
			flag_start[`CSSE_FL_ZERO]  = is_subtract_word_borrow_op ? (flag_r[`CSSE_FL_ZERO] && dres == 16'h0000) : (dres == 16'h0000);
			flag_start[`CSSE_FL_NEG]   = msb_r;
			flag_start[`CSSE_FL_CARRY] = !borrow;
			flag_start[`CSSE_FL_OVF]   = sub_ovf;
			flag_start[`CSSE_FL_VT]    = flag_r[`CSSE_FL_VT] || sub_ovf;
		end else if (is_xor) begin
			flag_start[`CSSE_FL_ZERO]  = (xres == 16'h0000);
			flag_start[`CSSE_FL_NEG]   = xmsb;
			flag_start[`CSSE_FL_CARRY] = 1'b0;
			flag_start[`CSSE_FL_OVF]   = 1'b0;
		end else if (is_shift_right_logical_dword) begin
			flag_start[`CSSE_FL_ZERO]   = (opnd_a == 32'h0000_0000);
			flag_start[`CSSE_FL_NEG]    = 1'b0;
			flag_start[`CSSE_FL_OVF]    = 1'b0;
			flag_start[`CSSE_FL_STICKY] = 1'b0;
		end
	end

	// ==========================================
	// shift step
	logic [31:0] work_r;
	logic [5:0]  sh_cnt_r;
	logic        sh_any_r;
	wire         step     = (state_r == csse_pkg::CSSE_RUN) && (sh_cnt_r != 6'h00);
	wire  [31:0] work_sh  = {1'b0, work_r[31:1]};
	wire         stk_set  = step && sh_any_r && flag_r[`CSSE_FL_CARRY];
	logic [5:0]  flag_step;
	always_comb begin
		flag_step = flag_r;
		if (step) begin
			flag_step[`CSSE_FL_CARRY]  = work_r[0];
			flag_step[`CSSE_FL_ZERO]   = (work_sh == 32'h0000_0000);
			flag_step[`CSSE_FL_STICKY] = flag_r[`CSSE_FL_STICKY] || stk_set;
		end
	end

	// ==========================================
	// next values
	logic [5:0]  st_cnt_r;
	logic [1:0]  wr_kind_r;
	wire  [31:0] work_ld = is_shift_right_logical_dword ? opnd_a : is_sub ? {16'h0000, dres} :
	                       is_xor ? {16'h0000, xres} : {16'h0000, store_v};
	wire         last    = (state_r == csse_pkg::CSSE_RUN) && (st_cnt_r == 6'h01);
	wire  [1:0]  state_nxt = start_ok ? csse_pkg::CSSE_RUN : last ? csse_pkg::CSSE_IDLE : state_r;
	wire         wr_nxt  = last && !run_trap_r && (wr_kind_r != 2'd3);
	logic [15:0] pc_hold_r;
	wire  [15:0] pc_nxt  = is_short_relative_jump ? jmp_pc : seq_pc;
	wire  [1:0]  kind_ld = (is_shift_right_logical_dword ? 2'd2 : (is_short_relative_jump || is_skip || is_trap || !known) ? 2'd3 :
	                        is_byte ? 2'd0 : 2'd1);

	// ==========================================
	// control
	always_ff @(posedge sys_clk or negedge rst_n_int) begin
		if (!rst_n_int) begin
			state_r    <= csse_pkg::CSSE_IDLE;
			st_cnt_r   <= 6'h00;
			sh_cnt_r   <= 6'h00;
			sh_any_r   <= 1'b0;
			run_trap_r <= 1'b0;
			wr_kind_r  <= 2'd3;
			pc_hold_r  <= 16'h0000;
		end else begin
			state_r    <= state_nxt;
			st_cnt_r   <= start_ok ? n_states : (state_r == csse_pkg::CSSE_RUN) ? st_cnt_r - 6'h01 : st_cnt_r;
			sh_cnt_r   <= (start_ok && is_shift_right_logical_dword) ? shift_n : step ? sh_cnt_r - 6'h01 : sh_cnt_r;
			sh_any_r   <= start_ok ? 1'b0 : (step || sh_any_r);
			run_trap_r <= start_ok ? is_trap : run_trap_r;
			wr_kind_r  <= start_ok ? kind_ld : wr_kind_r;
			pc_hold_r  <= start_ok ? pc_nxt : pc_hold_r;
		end
	end

	// ==========================================
	// datapath and outputs
	always_ff @(posedge sys_clk or negedge rst_n_int) begin
		if (!rst_n_int) begin
			work_r      <= 32'h0000_0000;
			flag_r      <= `CSSE_FLAGS_RST;
			busy        <= 1'b0;
			done        <= 1'b0;
			wr_en       <= 1'b0;
			wr_size     <= 2'd0;
			pc_out      <= 16'h0000;
			sp_wr       <= 1'b0;
			sp_out      <= 16'h0000;
			push_en     <= 1'b0;
			push_data   <= 16'h0000;
			vector_addr <= `CSSE_TRAP_VECTOR;
			int_block   <= 1'b0;
		end else begin
			work_r      <= start_ok ? work_ld : step ? work_sh : work_r;
			flag_r      <= start_ok ? flag_start : flag_step;
			busy        <= (state_nxt == csse_pkg::CSSE_RUN);
			done        <= last;
			wr_en       <= wr_nxt;
			wr_size     <= start_ok ? kind_ld : wr_size;
			pc_out      <= !last ? pc_out : run_trap_r ? vector_data : pc_hold_r;
			sp_wr       <= start_ok && is_trap;
			sp_out      <= (start_ok && is_trap) ? sp_in - `CSSE_SP_STEP : sp_out;
			push_en     <= start_ok && is_trap;
			push_data   <= (start_ok && is_trap) ? seq_pc : push_data;
			vector_addr <= `CSSE_TRAP_VECTOR;
			int_block   <= (last && run_trap_r) ? 1'b1 : last ? 1'b0 : int_block;
		end
	end

	assign result = work_r;
	assign flags  = flag_r;

	// ==========================================
	// checks
	sequence shr_go_s;
		start_ok && is_shift_right_logical_dword && shift_n == 6'h00;
	endsequence
	sequence shr_end_s;
		##9 done;
	endsequence
	shift_zero_time_a: assert property (@(posedge sys_clk) disable iff (!rst_n_int)
		shr_go_s |-> shr_end_s) else $error("zero shift not eight states");
	sticky_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n_int)
		start_ok && is_shift_right_logical_dword |=> !flag_r[`CSSE_FL_STICKY]) else $error("sticky not cleared");
	shift_two_a: assert property (@(posedge sys_clk) disable iff (!rst_n_int)
		start_ok && is_shift_right_logical_dword && shift_n == 6'h02 |-> ##10 done && result == ($past(opnd_a, 10) >> 2))
		else $error("two-step shift wrong");
	jump_target_a: assert property (@(posedge sys_clk) disable iff (!rst_n_int)
		start_ok && is_short_relative_jump |-> ##9 done && pc_out == $past(jmp_pc, 9)) else $error("jump wrong");
	skip_time_a: assert property (@(posedge sys_clk) disable iff (!rst_n_int)
		start_ok && is_skip |-> !done [*5] ##1 done) else $error("skip not four states");
	store_flags_a: assert property (@(posedge sys_clk) disable iff (!rst_n_int)
		start_ok && is_store |=> $stable(flag_r)) else $error("store moved flags");
	sub_carry_a: assert property (@(posedge sys_clk) disable iff (!rst_n_int)
		start_ok && is_sub |=> flag_r[`CSSE_FL_CARRY] == !$past(borrow)) else $error("carry not inverse borrow");
	xor_flags_a: assert property (@(posedge sys_clk) disable iff (!rst_n_int)
		start_ok && is_xor |=> !flag_r[`CSSE_FL_CARRY] && !flag_r[`CSSE_FL_OVF]) else $error("xor c or v set");
	trap_time_a: assert property (@(posedge sys_clk) disable iff (!rst_n_int)
		start_ok && is_trap && stack_onchip |-> ##1 push_en && sp_out == $past(sp_in) - 16'h0002 ##21 done)
		else $error("trap sequence wrong");
	trap_block_a: assert property (@(posedge sys_clk) disable iff (!rst_n_int)
		last && run_trap_r |=> int_block) else $error("interrupt not blocked after trap");
endmodule : csse_exec

//--- bench/csse_exec_tb.sv
/*
 self-checking bench for the shift, jump, store, subtract, trap and xor slice.
 assumes csse_exec and csse_map.svh on the include path; one 20 MHz clock.
*/
`timescale 1ns/1ps
`include "csse_map.svh"

module csse_exec_tb;
	// ==========================================
	// stimulus and observed signals
	logic        sys_clk, rstn, start, stack_onchip;
	logic [7:0]  opcode, second_byte, count_reg_val;
	logic [31:0] opnd_a;
	logic [15:0] opnd_b, pc_in, sp_in, vector_data;
	logic        busy, done, wr_en, sp_wr, push_en, int_block;
	logic [1:0]  wr_size;
	logic [31:0] result;
	logic [15:0] pc_out, sp_out, push_data, vector_addr, spo_seen, pd_seen;
	logic [5:0]  flags;
	logic        sp_seen, push_seen;
	int          err_count, tests_run, cyc;
	int          cea [4] = '{0, 1, 3, 4};
	int          bea [4] = '{0, 1, 0, 1};

	csse_exec DUT (.sys_clk(sys_clk), .rstn(rstn), .start(start), .opcode(opcode),
		.second_byte(second_byte), .count_reg_val(count_reg_val), .opnd_a(opnd_a), .opnd_b(opnd_b),
		.pc_in(pc_in), .sp_in(sp_in), .stack_onchip(stack_onchip), .vector_data(vector_data),
		.busy(busy), .done(done), .wr_en(wr_en), .wr_size(wr_size), .result(result), .pc_out(pc_out),
		.sp_wr(sp_wr), .sp_out(sp_out), .push_en(push_en), .push_data(push_data),
		.vector_addr(vector_addr), .flags(flags), .int_block(int_block));

	// ==========================================
	// clock and timeout
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count = err_count + 1;
			report_and_stop();
		end
	end

	// ==========================================
	// tasks
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run = tests_run + 1;
		if (seen !== exp) begin
			err_count = err_count + 1;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// issue one instruction, count states to done
	task automatic exec(input logic [7:0] op, input logic [7:0] sb, input logic [31:0] a,
		input logic [15:0] b, input int states, input logic exp_wr);
		int n;
		n = 0;
		@(posedge sys_clk);
		opcode      <= op;
		second_byte <= sb;
		opnd_a      <= a;
		opnd_b      <= b;
		start       <= 1'b1;
		@(posedge sys_clk);
		start <= 1'b0;
		#1;
		sp_seen   = sp_wr;
		push_seen = push_en;
		spo_seen  = sp_out;
		pd_seen   = push_data;
		check("busy", busy, 1'b1);
		while (n < 40) begin
			@(posedge sys_clk);
			#1;
			n = n + 1;
			if (done === 1'b1)
				break;
		end
		check("states", n, states);
		check("wr_en", wr_en, exp_wr);
	endtask : exec

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop

	// ==========================================
	// main sequence
	initial begin
		rstn = 1'b0; start = 1'b0; stack_onchip = 1'b1; opcode = 8'h00; second_byte = 8'h00;
		count_reg_val = 8'h00; opnd_a = 32'h0; opnd_b = 16'h0; pc_in = 16'h1000;
		sp_in = 16'h0200; vector_data = 16'h3456; err_count = 0; tests_run = 0; cyc = 0;
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		// two-byte no-operation, second byte ignored
		exec(8'h00, 8'ha5, 32'h0, 16'h0, 4, 1'b0);
		check("pc", pc_out, 16'h1002);
		// logical right shift, immediate count 2
		exec(8'h0c, 8'h02, 32'h8000_0003, 16'h0, 9, 1'b1);
		check("res", result, 32'h2000_0000);
		check("c st z", {flags[`CSSE_FL_CARRY], flags[`CSSE_FL_STICKY], flags[`CSSE_FL_ZERO]}, 3'b110);
		check("size", wr_size, 2'h2);
		check("pc", pc_out, 16'h1003);
		exec(8'h0c, 8'h00, 32'h1234_5678, 16'h0, 8, 1'b1);
		check("res", result, 32'h1234_5678);
		check("st", flags[`CSSE_FL_STICKY], 1'b0);
		// count taken from a register at address 16
		count_reg_val <= 8'h05;
		exec(8'h0c, 8'h10, 32'h0000_0010, 16'h0, 12, 1'b1);
		check("res", result, 32'h0);
		check("c st z", {flags[`CSSE_FL_CARRY], flags[`CSSE_FL_STICKY], flags[`CSSE_FL_ZERO]}, 3'b101);
		exec(8'h0c, 8'h0f, 32'hffff_ffff, 16'h0, 22, 1'b1);
		check("res", result, 32'h0001_ffff);
		check("c st z", {flags[`CSSE_FL_CARRY], flags[`CSSE_FL_STICKY], flags[`CSSE_FL_ZERO]}, 3'b110);
		// short jump at both displacement limits
		exec(8'h24, 8'h00, 32'h0, 16'h0, 8, 1'b0);
		check("pc", pc_out, 16'h0c02);
		exec(8'h23, 8'hff, 32'h0, 16'h0, 8, 1'b0);
		check("pc", pc_out, 16'h1401);
		// stores in every addressing mode, flags untouched
		for (int aa = 0; aa < 4; aa++) begin
			exec(8'hc0 | 8'(aa), 8'h0, 32'h0000_beef, 16'h0, 4 + cea[aa], 1'b1);
			check("res", result[15:0], 16'hbeef);
			check("size", wr_size, 2'h1);
			check("pc", pc_out, 16'h1002 + 16'(bea[aa]));
			exec(8'hc4 | 8'(aa), 8'h0, 32'h0000_0042, 16'h0, 4 + cea[aa], 1'b1);
			check("res", result[7:0], 8'h42);
			check("size", wr_size, 2'h0);
			check("c st z", {flags[`CSSE_FL_CARRY], flags[`CSSE_FL_STICKY], flags[`CSSE_FL_ZERO]}, 3'b110);
		end
		// subtracts
		exec(8'h68, 8'h0, 32'h5, 16'h7, 4, 1'b1);
		check("res", result[15:0], 16'hfffe);
		check("st v c n z", {flags[5], flags[3:0]}, 5'b10010);
		exec(8'hb8, 8'h0, 32'h10, 16'h5, 4, 1'b1);
		check("res", result[7:0], 8'h0a);
		check("c", flags[`CSSE_FL_CARRY], 1'b1);
		exec(8'ha8, 8'h0, 32'h1234, 16'h0234, 4, 1'b1);
		check("res", result[15:0], 16'h1000);
		exec(8'h78, 8'h0, 32'h80, 16'h1, 4, 1'b1);
		check("res", result[7:0], 8'h7f);
		check("vt v c n", flags[4:1], 4'b1110);
		exec(8'h49, 8'h0, 32'h8000, 16'h8000, 6, 1'b1);
		check("res", result[15:0], 16'h0);
		check("pc", pc_out, 16'h1004);
		exec(8'h5a, 8'h0, 32'h3, 16'h4, 8, 1'b1);
		check("res", result[7:0], 8'hff);
		check("c n", flags[2:1], 2'b01);
		// exclusive-or word and byte
		exec(8'h87, 8'h0, 32'h00ff, 16'h0f0f, 8, 1'b1);
		check("res", result[15:0], 16'h0ff0);
		check("flags", flags, 6'b110000);
		check("pc", pc_out, 16'h1003);
		exec(8'h94, 8'h0, 32'h55, 16'h55, 4, 1'b1);
		check("res", result[7:0], 8'h00);
		check("flags", flags, 6'b110001);
		// software trap, both stack placements
		exec(8'hf7, 8'h0, 32'h0, 16'h0, 21, 1'b0);
		check("push", {sp_seen, push_seen}, 2'b11);
		check("sp", spo_seen, 16'h01fe);
		check("pushd", pd_seen, 16'h1001);
		check("vaddr", vector_addr, 16'h2010);
		check("pc", pc_out, 16'h3456);
		check("blk", int_block, 1'b1);
		stack_onchip <= 1'b0;
		vector_data  <= 16'h4567;
		exec(8'hf7, 8'h0, 32'h0, 16'h0, 24, 1'b0);
		check("pc", pc_out, 16'h4567);
		exec(8'h00, 8'h3c, 32'h0, 16'h0, 4, 1'b0);
		check("blk", int_block, 1'b0);
		check("flags", flags, 6'b110001);
		report_and_stop();
	end
endmodule : csse_exec_tb
